// *** common/dlpc_pkg.sv ***
// Shared constants and carrier types for the debug link PHY config/status bank.
// Assumes one system clock; the link framer and access layer sit outside.
package dlpc_pkg;
  localparam logic [3:0] ADDR_REV_STATUS = 4'h0;
  localparam logic [3:0] ADDR_ERR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_PHY_CTRL = 4'h2;
  localparam logic [3:0] ADDR_PHY_CTRL2 = 4'h3;
  localparam logic [3:0] ADDR_PHY_LAST = 4'h3;
  localparam logic [3:0] ADDR_KEY_STATUS = 4'h7;
  localparam logic [3:0] ADDR_RESET_REQ = 4'h8;
  localparam logic [3:0] ADDR_CLK_CTRL = 4'h9;
  localparam logic [3:0] ADDR_SYS_CTRL = 4'hA;
  localparam logic [3:0] ADDR_SYS_STATUS = 4'hB;
  localparam logic [3:0] ADDR_CRC_STATUS = 4'hC;
  localparam logic [3:0] ADDR_LAST = 4'hC;
  // Control field positions
  localparam int CTRL_GAP_BIT = 7;
  localparam int CTRL_PARITY_IGN_BIT = 5;
  localparam int CTRL_TMO_DIS_BIT = 4;
  localparam int CTRL_RSP_SUP_BIT = 3;
  localparam logic [7:0] CTRL_WR_MASK = 8'hBF;
  localparam logic [7:0] PHY_CTRL_RESET = 8'h00;
  localparam logic [7:0] CLK_CTRL_RESET = 8'h03;
  localparam logic [7:0] SYS_CTRL_RESET = 8'h01;
  localparam logic [7:0] RESET_REQ_CODE = 8'h59;
  // Error signature codes
  localparam logic [2:0] SIG_NONE = 3'h0;
  localparam logic [2:0] SIG_PARITY = 3'h1;
  localparam logic [2:0] SIG_FRAME = 3'h2;
  localparam logic [2:0] SIG_TIMEOUT = 3'h3;
  localparam logic [2:0] SIG_CLK_REC = 3'h4;
  localparam logic [2:0] SIG_CONTENTION = 3'h7;
  // Timing
  localparam int TMO_CYCLES = 65536;
  localparam int GAP_IDLE_CHARS = 2;
  localparam int CHAR_BITS = 12;
  localparam int GAP_CYCLES = GAP_IDLE_CHARS * CHAR_BITS;
  // Register access from the link framer
  typedef struct packed {
    logic rd;
    logic wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } dlpc_reg_req_t;
  // Link event strobes from the receiver
  typedef struct packed {
    logic parity_err;
    logic frame_err;
    logic start_err;
    logic contention;
  } dlpc_rx_err_t;
endpackage

// *** design/dlpc_turn_timer.sv ***
// Idle-cycle timer for turnaround guard and inter-byte gap.
// Assumes the transmitter asks for a delay with a one-cycle start pulse.
`timescale 1ns/1ns
module dlpc_turn_timer
  import dlpc_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic start_in,
  input wire logic [7:0] cycles_in,
  output logic busy_out
);
  logic [7:0] count;

  // Zero cycles means no delay at all
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      count <= 8'h00;
      busy_out <= 1'b0;
    end
    else if (start_in)
    begin
      count <= cycles_in;
      busy_out <= (cycles_in != 8'h00);
    end
    else if (count > 8'h01)
    begin
      count <= count - 8'h01;
    end
    else
    begin
      count <= 8'h00;
      busy_out <= 1'b0;
    end
  end
endmodule

// *** design/dlpc_top.sv ***
// PHY configuration/status bank of the single-wire debug link.
// Register port is driven only by the link framer; the CPU has no path here.
`timescale 1ns/1ns
module dlpc_top
  import dlpc_pkg::*;
#(
  parameter logic [3:0] REVISION = 4'h1, // Arbitrary value
  parameter int TMO_LIMIT = TMO_CYCLES
)
(
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire dlpc_reg_req_t reg_req_in,
  input wire dlpc_rx_err_t rx_err_in,
  input wire logic acc_req_in,
  input wire logic acc_rsp_in,
  input wire logic tx_turn_in,
  input wire logic tx_byte_done_in,
  input wire logic tx_multi_in,
  input wire logic [7:0] key_status_in,
  input wire logic [7:0] sys_status_in,
  input wire logic [7:0] crc_status_in,
  output logic [7:0] rdata_out,
  output logic rvalid_out,
  output logic tx_hold_out,
  output logic rsp_sig_enable_out,
  output logic sys_reset_out,
  output logic [7:0] clk_select_out,
  output logic [7:0] sys_ctrl_out
);
  logic [7:0] phy_ctrl;
  logic [7:0] phy_ctrl2;
  logic [2:0] err_sig;
  logic [7:0] clk_ctrl;
  logic [7:0] sys_ctrl;
  logic [16:0] tmo_count;
  logic tmo_active;
  logic tmo_hit;
  logic [2:0] next_sig;
  logic next_err;
  logic err_rd;
  logic timer_start;
  logic [7:0] timer_cycles;
  logic timer_busy;
  logic [7:0] guard_cycles;

  // Link-side register access only
  assign err_rd = reg_req_in.rd && (reg_req_in.addr == ADDR_ERR_STATUS);

  // Control register writes; bit 6 stays zero except in PHY_CTRL2, which takes all eight bits
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      phy_ctrl <= PHY_CTRL_RESET;
      phy_ctrl2 <= PHY_CTRL_RESET;
      clk_ctrl <= CLK_CTRL_RESET;
      sys_ctrl <= SYS_CTRL_RESET;
    end
    else if (reg_req_in.wr)
    begin
      unique case (reg_req_in.addr)
        ADDR_PHY_CTRL: phy_ctrl <= reg_req_in.wdata & CTRL_WR_MASK;
        ADDR_PHY_CTRL2: phy_ctrl2 <= reg_req_in.wdata;
        ADDR_CLK_CTRL: clk_ctrl <= reg_req_in.wdata & 8'h03;
        ADDR_SYS_CTRL: sys_ctrl <= reg_req_in.wdata & 8'h03;
        default: ;
      endcase
    end
  end

  // Reset request holds while signature is present
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      sys_reset_out <= 1'b0;
    else if (reg_req_in.wr && reg_req_in.addr == ADDR_RESET_REQ)
      sys_reset_out <= (reg_req_in.wdata == RESET_REQ_CODE);
  end

  // Access layer time-out counter
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      tmo_count <= 17'h00000;
      tmo_active <= 1'b0;
    end
    else if (acc_req_in)
    begin
      tmo_count <= 17'h00000;
      tmo_active <= 1'b1;
    end
    else if (acc_rsp_in || tmo_hit)
      tmo_active <= 1'b0;
    else if (tmo_active)
      tmo_count <= tmo_count + 17'h00001;
  end

  assign tmo_hit = tmo_active && !acc_rsp_in && !phy_ctrl[CTRL_TMO_DIS_BIT]
                   && (tmo_count == 17'(TMO_LIMIT - 1));

  // Error priority: contention, then start, frame, parity, time-out
  always_comb
  begin
    next_err = 1'b1;
    if (rx_err_in.contention)
      next_sig = SIG_CONTENTION;
    else if (rx_err_in.start_err)
      next_sig = SIG_CLK_REC;
    else if (rx_err_in.frame_err)
      next_sig = SIG_FRAME;
    else if (rx_err_in.parity_err && !phy_ctrl[CTRL_PARITY_IGN_BIT])
      next_sig = SIG_PARITY;
    else if (tmo_hit)
      next_sig = SIG_TIMEOUT;
    else
    begin
      next_sig = SIG_NONE;
      next_err = 1'b0;
    end
  end

  // New error wins over the clear-on-read in the same cycle
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
      err_sig <= SIG_NONE;
    else if (next_err)
      err_sig <= next_sig;
    else if (err_rd)
      err_sig <= SIG_NONE;
  end

  // Read data; unmapped and reserved offsets read zero
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      rdata_out <= 8'h00;
      rvalid_out <= 1'b0;
    end
    else
    begin
      rvalid_out <= reg_req_in.rd;
      if (reg_req_in.rd)
      begin
        unique case (reg_req_in.addr)
          ADDR_REV_STATUS: rdata_out <= {REVISION, 4'h0};
          ADDR_ERR_STATUS: rdata_out <= {5'h00, err_sig};
          ADDR_PHY_CTRL: rdata_out <= phy_ctrl;
          ADDR_PHY_CTRL2: rdata_out <= phy_ctrl2;
          ADDR_KEY_STATUS: rdata_out <= key_status_in;
          ADDR_RESET_REQ: rdata_out <= {7'h00, sys_reset_out};
          ADDR_CLK_CTRL: rdata_out <= clk_ctrl;
          ADDR_SYS_CTRL: rdata_out <= sys_ctrl;
          ADDR_SYS_STATUS: rdata_out <= sys_status_in;
          ADDR_CRC_STATUS: rdata_out <= crc_status_in;
          default: rdata_out <= 8'h00;
        endcase
      end
    end
  end

  // Guard time decode: 128 >> code, code 7 means none
  always_comb
  begin
    if (phy_ctrl[2:0] == 3'h7)
      guard_cycles = 8'h00;
    else
      guard_cycles = 8'h80 >> phy_ctrl[2:0];
  end

  // Turnaround uses guard only; later load bytes add the two-char gap
  always_comb
  begin
    timer_start = 1'b0;
    timer_cycles = 8'h00;
    if (tx_turn_in)
    begin
      timer_start = 1'b1;
      timer_cycles = guard_cycles;
    end
    else if (tx_byte_done_in && tx_multi_in && phy_ctrl[CTRL_GAP_BIT])
    begin
      timer_start = 1'b1;
      timer_cycles = 8'(GAP_CYCLES);
    end
  end

  dlpc_turn_timer u_timer (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .start_in(timer_start),
    .cycles_in(timer_cycles),
    .busy_out(timer_busy)
  );

  // Registered outputs to the transmitter and access layer
  always_ff @(posedge clk_sys_in)
  begin
    if (reset_in)
    begin
      tx_hold_out <= 1'b0;
      rsp_sig_enable_out <= 1'b1;
      clk_select_out <= CLK_CTRL_RESET;
      sys_ctrl_out <= SYS_CTRL_RESET;
    end
    else
    begin
      tx_hold_out <= timer_busy || timer_start;
      rsp_sig_enable_out <= !phy_ctrl[CTRL_RSP_SUP_BIT];
      clk_select_out <= clk_ctrl;
      sys_ctrl_out <= sys_ctrl;
    end
  end

  // Assertions
  a_read_clears_sig: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (err_rd && !next_err) |=> (err_sig == SIG_NONE))
    else $error("signature not cleared by read");
  a_parity_ignored: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (phy_ctrl[CTRL_PARITY_IGN_BIT] && !$past(next_err)) |-> err_sig != SIG_PARITY
    || $past(err_sig) == SIG_PARITY)
    else $error("parity flagged while ignored");
  a_tmo_disabled: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    phy_ctrl[CTRL_TMO_DIS_BIT] |-> !tmo_hit)
    else $error("time-out while check disabled");
  a_contention_code: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    rx_err_in.contention |=> err_sig == SIG_CONTENTION)
    else $error("contention code missing");
  a_reset_req_hold: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (reg_req_in.wr && reg_req_in.addr == ADDR_RESET_REQ
     && reg_req_in.wdata == RESET_REQ_CODE) |=> sys_reset_out)
    else $error("system reset not asserted");
  a_rsp_suppress: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    $rose(phy_ctrl[CTRL_RSP_SUP_BIT]) |=> !rsp_sig_enable_out)
    else $error("response signature not suppressed");
  a_gap_length: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (timer_start && timer_cycles == 8'(GAP_CYCLES)) |=> timer_busy [*8])
    else $error("inter-byte gap too short");
  a_guard_off: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (tx_turn_in && phy_ctrl[2:0] == 3'h7) |=> !timer_busy)
    else $error("guard inserted when off");
  a_rev_read: assert property (@(posedge clk_sys_in) disable iff (reset_in)
    (reg_req_in.rd && reg_req_in.addr == ADDR_REV_STATUS)
    |=> rdata_out[7:4] == REVISION)
    else $error("revision field wrong");
endmodule

// *** verification/dlpc_host.sv ***
// Debugger-side model: link register accesses plus the access layer's answers.
// Assumes one calling process in the bench, timed by clk_sys_in.
`timescale 1ns/1ns
module dlpc_host
  import dlpc_pkg::*;
(
  input wire logic clk_sys_in,
  output dlpc_reg_req_t reg_req_out,
  output logic acc_req_out,
  output logic acc_rsp_out
);
  // Idle bus until a task runs
  initial
  begin
    reg_req_out = '0;
    acc_req_out = 1'b0;
    acc_rsp_out = 1'b0;
  end
  // One-cycle strobe, moved 1 ns after the edge so sampling never races
  task automatic req(input logic r, input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys_in);
    #1;
    reg_req_out = '{rd: r, wr: !r, addr: a, wdata: d};
    @(posedge clk_sys_in);
    #1;
    reg_req_out = '0;
  endtask
  // Fixed answer latency; no answer models a sleeping system
  task automatic access(input int dly, input bit answer);
    @(posedge clk_sys_in);
    #1;
    acc_req_out = 1'b1;
    @(posedge clk_sys_in);
    #1;
    acc_req_out = 1'b0;
    if (answer)
    begin
      repeat (dly) @(posedge clk_sys_in);
      #1;
      acc_rsp_out = 1'b1;
      @(posedge clk_sys_in);
      #1;
      acc_rsp_out = 1'b0;
    end
  endtask
endmodule

// *** verification/dlpc_top_test.sv ***
// Self-checking bench for the link config/status bank.
// Assumes the debugger model drives the register port; time-out shortened to 64.
`timescale 1ns/1ns
module dlpc_top_test
  import dlpc_pkg::*;
;
  localparam logic [3:0] REV = 4'h5; // Arbitrary revision value
  localparam int TMO = 64;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  dlpc_reg_req_t reg_req;
  dlpc_rx_err_t rx_err = '0;
  logic acc_req, acc_rsp, rvalid, tx_hold, rsp_en, sys_rst;
  logic tx_turn = 1'b0, tx_done = 1'b0, tx_multi = 1'b0;
  logic [7:0] key_st = 8'h28, sys_st = 8'h11, crc_st = 8'h05;
  logic [7:0] rdata, clk_sel, sys_ctrl;
  logic [2:0] sig_tab [4] = '{SIG_PARITY, SIG_FRAME, SIG_CLK_REC, SIG_CONTENTION};
  int err_total = 0, compares = 0, cyc = 0, n;

  always #25 clk_sys_in = ~clk_sys_in;

  dlpc_host host_u (.clk_sys_in(clk_sys_in), .reg_req_out(reg_req), .acc_req_out(acc_req),
    .acc_rsp_out(acc_rsp));
  dlpc_top #(.REVISION(REV), .TMO_LIMIT(TMO)) dut_u (.clk_sys_in(clk_sys_in),
    .reset_in(reset_in), .reg_req_in(reg_req), .rx_err_in(rx_err), .acc_req_in(acc_req),
    .acc_rsp_in(acc_rsp), .tx_turn_in(tx_turn), .tx_byte_done_in(tx_done),
    .tx_multi_in(tx_multi), .key_status_in(key_st), .sys_status_in(sys_st),
    .crc_status_in(crc_st), .rdata_out(rdata), .rvalid_out(rvalid), .tx_hold_out(tx_hold),
    .rsp_sig_enable_out(rsp_en), .sys_reset_out(sys_rst), .clk_select_out(clk_sel),
    .sys_ctrl_out(sys_ctrl));

  task automatic close_out;
    if (err_total == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Read data is looked at in the single cycle that rvalid stands
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    host_u.req(1'b1, a, 8'h00);
    chk("rvalid", 8'h01, {7'h00, rvalid});
    chk($sformatf("reg %h", a), exp, rdata);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    host_u.req(1'b0, a, d);
  endtask
  task automatic pulse_err(input logic [3:0] v);
    @(posedge clk_sys_in);
    #1;
    rx_err = dlpc_rx_err_t'(v);
    @(posedge clk_sys_in);
    #1;
    rx_err = '0;
  endtask
  // Counts the hold cycles after a turnaround or byte-done pulse
  task automatic hold_len(input logic [7:0] ctrl, input bit turn, input int exp);
    wr(ADDR_PHY_CTRL, ctrl);
    @(posedge clk_sys_in);
    #1;
    tx_turn = turn;
    tx_done = !turn;
    @(posedge clk_sys_in);
    #1;
    tx_turn = 1'b0;
    tx_done = 1'b0;
    n = 0;
    repeat (300)
    begin
      if (tx_hold === 1'b1)
        n++;
      else if (n > 0)
        break;
      @(posedge clk_sys_in);
      #1;
    end
    chk("hold cycles", exp[7:0], n[7:0]);
  endtask

  // Hang guard, well above the fewer than one thousand cycles the sequence needs
  always @(posedge clk_sys_in)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_total++;
      close_out();
    end
  end

  initial
  begin
    repeat (2) @(posedge clk_sys_in);
    #1;
    reset_in = 1'b0;
    chk("outputs", 8'h11, {3'h0, rsp_en, sys_rst, tx_hold, sys_ctrl[1:0]});
    chk("clk select", CLK_CTRL_RESET, clk_sel);
    rd(ADDR_REV_STATUS, {REV, 4'h0});
    wr(ADDR_REV_STATUS, 8'hFF);
    rd(ADDR_REV_STATUS, {REV, 4'h0});
    rd(ADDR_ERR_STATUS, 8'h00);
    rd(ADDR_PHY_CTRL, PHY_CTRL_RESET);
    // Every receiver error source, then the clear that the read leaves behind
    for (int i = 0; i < 4; i++)
    begin
      pulse_err(4'h8 >> i);
      rd(ADDR_ERR_STATUS, {5'h00, sig_tab[i]});
      rd(ADDR_ERR_STATUS, 8'h00);
    end
    pulse_err(4'h8);
    pulse_err(4'h4);
    rd(ADDR_ERR_STATUS, {5'h00, SIG_FRAME});
    wr(ADDR_PHY_CTRL, 8'h20);
    pulse_err(4'h8);
    rd(ADDR_ERR_STATUS, 8'h00);
    wr(ADDR_PHY_CTRL, 8'h00);
    host_u.access(0, 1'b0);
    repeat (TMO + 8) @(posedge clk_sys_in);
    rd(ADDR_ERR_STATUS, {5'h00, SIG_TIMEOUT});
    host_u.access(TMO / 2, 1'b1);
    host_u.access(TMO / 2, 1'b1);
    repeat (TMO + 8) @(posedge clk_sys_in);
    rd(ADDR_ERR_STATUS, 8'h00);
    wr(ADDR_PHY_CTRL, 8'h10);
    host_u.access(0, 1'b0);
    repeat (TMO + 8) @(posedge clk_sys_in);
    rd(ADDR_ERR_STATUS, 8'h00);
    wr(ADDR_PHY_CTRL, 8'hFF);
    rd(ADDR_PHY_CTRL, CTRL_WR_MASK);
    chk("rsp sig enable", 8'h00, {7'h00, rsp_en});
    hold_len(8'h00, 1'b1, 129);
    hold_len(8'h03, 1'b1, 17);
    hold_len(8'h06, 1'b1, 3);
    hold_len(8'h07, 1'b1, 1);
    hold_len(8'h82, 1'b1, 33);
    tx_multi = 1'b1;
    hold_len(8'h87, 1'b0, GAP_CYCLES + 1);
    hold_len(8'h07, 1'b0, 0);
    tx_multi = 1'b0;
    wr(ADDR_RESET_REQ, RESET_REQ_CODE);
    rd(ADDR_RESET_REQ, 8'h01);
    chk("sys reset", 8'h01, {7'h00, sys_rst});
    wr(ADDR_RESET_REQ, 8'h00);
    rd(ADDR_RESET_REQ, 8'h00);
    chk("sys reset", 8'h00, {7'h00, sys_rst});
    rd(ADDR_KEY_STATUS, key_st);
    rd(ADDR_SYS_STATUS, sys_st);
    rd(ADDR_CRC_STATUS, crc_st);
    rd(4'h5, 8'h00);
    rd(4'hF, 8'h00);
    wr(ADDR_CLK_CTRL, 8'h01);
    wr(ADDR_SYS_CTRL, 8'h00);
    rd(ADDR_CLK_CTRL, 8'h01);
    chk("clk select", 8'h01, clk_sel);
    chk("sys ctrl", 8'h00, sys_ctrl);
    close_out();
  end
endmodule
